// ### hw/gpp_pkg.sv
package gpp_pkg;
  // Register byte offsets, one aligned word each
  localparam logic [11:0] OFF_PIN_LEVEL = 12'h0000;
  localparam logic [11:0] OFF_LATCH     = 12'h0004;
  localparam logic [11:0] OFF_DIR       = 12'h0008;
  localparam logic [11:0] OFF_ANSEL     = 12'h000C;
  localparam logic [11:0] OFF_WPU       = 12'h0010;
  localparam logic [11:0] OFF_THRESH    = 12'h0014;
  localparam logic [11:0] OFF_SLEW      = 12'h0018;
  localparam logic [11:0] OFF_OD        = 12'h001C;
  // Reset values, sliced to the port width by the users
  localparam logic [31:0] RST_LATCH     = 32'h0000_0000;
  localparam logic [31:0] RST_DIR       = 32'hFFFF_FFFF;
  localparam logic [31:0] RST_ANSEL     = 32'h0000_0000;
  localparam logic [31:0] RST_WPU       = 32'h0000_0000;
  localparam logic [31:0] RST_THRESH    = 32'h0000_0000;
  localparam logic [31:0] RST_SLEW      = 32'hFFFF_FFFF;
  localparam logic [31:0] RST_OD        = 32'h0000_0000;
  // AXI4-Lite responses
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;
endpackage : gpp_pkg

// ### hw/gpp_mux_if.sv
`timescale 1ns/1ns
`default_nettype none
interface gpp_mux_if #(
  parameter int N = 8
);
  logic [N-1:0] latch;
  logic [N-1:0] dir;
  logic [N-1:0] ansel;
  logic [N-1:0] od;
  logic [N-1:0] periph_en;
  logic [N-1:0] periph_out;
  logic [N-1:0] aout_en;
  logic [N-1:0] cfg_own;
  logic [N-1:0] cfg_out;
  logic [N-1:0] cfg_oe_b;
  logic [N-1:0] pad_o;
  logic [N-1:0] pad_oe_b;

  modport ctl (
    output latch, dir, ansel, od, periph_en, periph_out,
    output aout_en, cfg_own, cfg_out, cfg_oe_b,
    input  pad_o, pad_oe_b
  );
  modport mux (
    input  latch, dir, ansel, od, periph_en, periph_out,
    input  aout_en, cfg_own, cfg_out, cfg_oe_b,
    output pad_o, pad_oe_b
  );
endinterface : gpp_mux_if
`default_nettype wire

// ### hw/gpp_pin_mux.sv
`timescale 1ns/1ns
`default_nettype none
module gpp_pin_mux
  import gpp_pkg::*;
#(
  parameter int N = 8
) (
  input  wire logic clk_i,
  input  wire logic rst_b_i,
  gpp_mux_if.mux    m
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  genvar i;
  generate
    for (i = 0; i < N; i++) begin : g_pin
      logic src;
      logic po;
      logic oe_b;
      assign src = m.periph_en[i] ? m.periph_out[i] : m.latch[i];
      always_comb begin
        if (m.cfg_own[i]) begin
          po   = m.cfg_out[i];
          oe_b = m.cfg_oe_b[i];
        end else if (m.aout_en[i]) begin
          po   = 1'b0;
          oe_b = 1'b1;
        end else begin
          po   = src;
          oe_b = m.dir[i] | (m.od[i] & src);
        end
      end
      assign m.pad_o[i]    = po;
      assign m.pad_oe_b[i] = oe_b;

      a_cfg_first: assert property (
        m.cfg_own[i] |-> (m.pad_o[i] == m.cfg_out[i]) && (m.pad_oe_b[i] == m.cfg_oe_b[i]))
        else $error("config ownership not honoured");
      a_aout_hiz: assert property (
        (m.aout_en[i] && !m.cfg_own[i]) |-> m.pad_oe_b[i])
        else $error("analog output left driver on");
      a_dir_input: assert property (
        (!m.cfg_own[i] && !m.aout_en[i] && m.dir[i]) |-> m.pad_oe_b[i])
        else $error("input pin driven");
      a_out_drive: assert property (
        (!m.cfg_own[i] && !m.aout_en[i] && !m.dir[i] && !m.od[i]) |-> !m.pad_oe_b[i])
        else $error("output pin not driven");
      a_od_low_only: assert property (
        (m.od[i] && !m.cfg_own[i]) |-> (m.pad_oe_b[i] || !m.pad_o[i]))
        else $error("open drain drove high");
      a_periph_src: assert property (
        (m.periph_en[i] && !m.cfg_own[i] && !m.aout_en[i]) |-> (m.pad_o[i] == m.periph_out[i]))
        else $error("peripheral data not on pin");
      a_ansel_drives: assert property (
        (m.ansel[i] && !m.cfg_own[i] && !m.aout_en[i] && !m.dir[i] && !m.periph_en[i]
         && !m.od[i]) |-> (!m.pad_oe_b[i] && (m.pad_o[i] == m.latch[i])))
        else $error("analog select stopped digital drive");
    end
  endgenerate
endmodule : gpp_pin_mux
`default_nettype wire

// ### hw/gpp_port.sv
// Implementation choices: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ns
`default_nettype none
module gpp_port
  import gpp_pkg::*;
#(
  parameter int N = 8
) (
  input  wire logic         clk_i,
  input  wire logic         rst_b_i,
  // AXI4-Lite slave
  input  wire logic [11:0]  s_awaddr_i,
  input  wire logic         s_awvalid_i,
  output logic              s_awready_o,
  input  wire logic [31:0]  s_wdata_i,
  input  wire logic [3:0]   s_wstrb_i,
  input  wire logic         s_wvalid_i,
  output logic              s_wready_o,
  output logic [1:0]        s_bresp_o,
  output logic              s_bvalid_o,
  input  wire logic         s_bready_i,
  input  wire logic [11:0]  s_araddr_i,
  input  wire logic         s_arvalid_i,
  output logic              s_arready_o,
  output logic [31:0]       s_rdata_o,
  output logic [1:0]        s_rresp_o,
  output logic              s_rvalid_o,
  input  wire logic         s_rready_i,
  // Pins, enable low while driving
  input  wire logic [N-1:0] pad_i,
  output logic [N-1:0]      pad_o,
  output logic [N-1:0]      pad_oe_b_o,
  output logic [N-1:0]      pullup_en_o,
  output logic [N-1:0]      thresh_sel_o,
  output logic [N-1:0]      slew_lim_o,
  // Digital input to peripherals, analog input switch
  output logic [N-1:0]      din_o,
  output logic [N-1:0]      ana_in_en_o,
  // Peripheral pin select, analog output, configuration owners
  input  wire logic [N-1:0] periph_en_i,
  input  wire logic [N-1:0] periph_out_i,
  input  wire logic [N-1:0] aout_en_i,
  input  wire logic [N-1:0] cfg_own_i,
  input  wire logic [N-1:0] cfg_out_i,
  input  wire logic [N-1:0] cfg_oe_b_i
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  logic [N-1:0]  latch_q;
  logic [N-1:0]  dir_q;
  logic [N-1:0]  ansel_q;
  logic [N-1:0]  wpu_q;
  logic [N-1:0]  thresh_q;
  logic [N-1:0]  slew_q;
  logic [N-1:0]  od_q;
  logic [N-1:0]  sync1_q;
  logic [N-1:0]  sync2_q;
  logic [N-1:0]  din_q;
  logic [N-1:0]  pad_q;
  logic [N-1:0]  pad_oe_b_q;
  logic          aw_have_q;
  logic [11:0]   aw_addr_q;
  logic          w_have_q;
  logic [31:0]   w_data_q;
  logic [3:0]    w_strb_q;
  logic          bvalid_q;
  logic [1:0]    bresp_q;
  logic          rvalid_q;
  logic [1:0]    rresp_q;
  logic [31:0]   rdata_q;
  logic          wr_fire;
  logic          wr_hit;
  logic [N-1:0]  wmask;
  logic          rd_fire;
  logic [N-1:0]  rd_val;
  logic          rd_hit;

  gpp_mux_if #(.N(N)) mif ();

  // Write channel: address and data taken in either order
  assign s_awready_o = !aw_have_q && !bvalid_q;
  assign s_wready_o  = !w_have_q && !bvalid_q;
  assign wr_fire     = aw_have_q && w_have_q && !bvalid_q;
  assign s_bvalid_o  = bvalid_q;
  assign s_bresp_o   = bresp_q;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      aw_have_q <= 1'b0;
      aw_addr_q <= 12'h000;
    end else if (s_awvalid_i && s_awready_o) begin
      aw_have_q <= 1'b1;
      aw_addr_q <= s_awaddr_i;
    end else if (wr_fire) begin
      aw_have_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      w_have_q <= 1'b0;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
    end else if (s_wvalid_i && s_wready_o) begin
      w_have_q <= 1'b1;
      w_data_q <= s_wdata_i;
      w_strb_q <= s_wstrb_i;
    end else if (wr_fire) begin
      w_have_q <= 1'b0;
    end
  end

  always_comb begin
    unique case ({aw_addr_q[11:2], 2'b00})
      OFF_PIN_LEVEL, OFF_LATCH, OFF_DIR, OFF_ANSEL,
      OFF_WPU, OFF_THRESH, OFF_SLEW, OFF_OD: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      bvalid_q <= 1'b0;
      bresp_q  <= RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_q <= 1'b1;
      bresp_q  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_bready_i) begin
      bvalid_q <= 1'b0;
    end
  end

  // Byte strobes widen to a bit mask
  genvar b;
  generate
    for (b = 0; b < N; b++) begin : g_mask
      assign wmask[b] = w_strb_q[b / 8];
    end
  endgenerate

  function automatic logic [N-1:0] merge(input logic [N-1:0] old_v);
    merge = (old_v & ~wmask) | (w_data_q[N-1:0] & wmask);
  endfunction : merge

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      latch_q <= RST_LATCH[N-1:0];
    end else if (wr_fire && ((aw_addr_q[11:2] == OFF_LATCH[11:2]) ||
                             (aw_addr_q[11:2] == OFF_PIN_LEVEL[11:2]))) begin
      latch_q <= merge(latch_q);
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      dir_q    <= RST_DIR[N-1:0];
      ansel_q  <= RST_ANSEL[N-1:0];
      wpu_q    <= RST_WPU[N-1:0];
      thresh_q <= RST_THRESH[N-1:0];
      slew_q   <= RST_SLEW[N-1:0];
      od_q     <= RST_OD[N-1:0];
    end else if (wr_fire) begin
      if (aw_addr_q[11:2] == OFF_DIR[11:2]) begin
        dir_q <= merge(dir_q);
      end
      if (aw_addr_q[11:2] == OFF_ANSEL[11:2]) begin
        ansel_q <= merge(ansel_q);
      end
      if (aw_addr_q[11:2] == OFF_WPU[11:2]) begin
        wpu_q <= merge(wpu_q);
      end
      if (aw_addr_q[11:2] == OFF_THRESH[11:2]) begin
        thresh_q <= merge(thresh_q);
      end
      if (aw_addr_q[11:2] == OFF_SLEW[11:2]) begin
        slew_q <= merge(slew_q);
      end
      if (aw_addr_q[11:2] == OFF_OD[11:2]) begin
        od_q <= merge(od_q);
      end
    end
  end

  // Pins are asynchronous; two stages before any use
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= pad_i;
      sync2_q <= sync1_q;
    end
  end

  // analog select blocks buffer
  // Blocked buffer reads zero, so half-level pins cannot toggle logic
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      din_q <= '0;
    end else begin
      din_q <= sync2_q & ~ansel_q;
    end
  end

  // Read channel: one read at a time, answer one cycle later
  assign s_arready_o = !rvalid_q;
  assign rd_fire     = s_arvalid_i && s_arready_o;
  assign s_rvalid_o  = rvalid_q;
  assign s_rdata_o   = rdata_q;
  assign s_rresp_o   = rresp_q;

  always_comb begin
    rd_val = '0;
    rd_hit = 1'b1;
    unique case ({s_araddr_i[11:2], 2'b00})
      OFF_PIN_LEVEL: rd_val = din_q;
      OFF_LATCH:     rd_val = latch_q;
      OFF_DIR:       rd_val = dir_q;
      OFF_ANSEL:     rd_val = ansel_q;
      OFF_WPU:       rd_val = wpu_q;
      OFF_THRESH:    rd_val = thresh_q;
      OFF_SLEW:      rd_val = slew_q;
      OFF_OD:        rd_val = od_q;
      default:       rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rvalid_q <= 1'b0;
      rresp_q  <= RESP_OKAY;
      rdata_q  <= 32'h0000_0000;
    end else if (rd_fire) begin
      rvalid_q <= 1'b1;
      rresp_q  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      rdata_q  <= 32'(rd_val);
    end else if (s_rready_i) begin
      rvalid_q <= 1'b0;
    end
  end

  // Pin arbitration
  assign mif.latch      = latch_q;
  assign mif.dir        = dir_q;
  assign mif.ansel      = ansel_q;
  assign mif.od         = od_q;
  assign mif.periph_en  = periph_en_i;
  assign mif.periph_out = periph_out_i;
  assign mif.aout_en    = aout_en_i;
  assign mif.cfg_own    = cfg_own_i;
  assign mif.cfg_out    = cfg_out_i;
  assign mif.cfg_oe_b   = cfg_oe_b_i;

  gpp_pin_mux #(.N(N)) u_mux (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .m       (mif.mux)
  );

  // Registered pin drive costs one cycle but keeps pads glitch free
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pad_q      <= '0;
      pad_oe_b_q <= '1;
    end else begin
      pad_q      <= mif.pad_o;
      pad_oe_b_q <= mif.pad_oe_b;
    end
  end

  assign pad_o        = pad_q;
  assign pad_oe_b_o   = pad_oe_b_q;
  assign pullup_en_o  = wpu_q;
  assign thresh_sel_o = thresh_q;
  assign slew_lim_o   = slew_q;
  assign din_o        = din_q;
  assign ana_in_en_o  = ansel_q;

  a_latch_read: assert property (
    (rd_fire && s_araddr_i[11:2] == OFF_LATCH[11:2]) |=>
      s_rvalid_o && (s_rdata_o[N-1:0] == $past(latch_q)))
    else $error("latch read wrong");
  a_pin_read: assert property (
    (rd_fire && s_araddr_i[11:2] == OFF_PIN_LEVEL[11:2]) |=>
      s_rvalid_o && (s_rdata_o[N-1:0] == $past(din_q)))
    else $error("pin level read wrong");
  a_pin_write: assert property (
    (wr_fire && aw_addr_q[11:2] == OFF_PIN_LEVEL[11:2] && w_strb_q == 4'hF) |=>
      (latch_q == $past(w_data_q[N-1:0])))
    else $error("pin register write missed latch");
  a_buffer_off: assert property (
    $past(ansel_q) != '0 |-> ((din_q & $past(ansel_q)) == '0))
    else $error("input buffer not disabled");
  a_pad_follow: assert property (
    (latch_q == $past(latch_q) && dir_q == '0 && od_q == '0 && periph_en_i == '0
     && aout_en_i == '0 && cfg_own_i == '0) |=> (pad_o == $past(latch_q)) && (pad_oe_b_o == '0))
    else $error("pin not following latch");
  a_analog_link: assert property (
    ana_in_en_o == ansel_q)
    else $error("analog input switch mismatch");
  a_write_resp: assert property (
    wr_fire |=> s_bvalid_o && (s_bresp_o == (($past(wr_hit)) ? RESP_OKAY : RESP_SLVERR)))
    else $error("write response missing");
  a_aout_pad: assert property (
    (aout_en_i[0] && !cfg_own_i[0]) |=> pad_oe_b_o[0])
    else $error("analog output pin still driven");
  a_latch_write: assert property (
    (wr_fire && aw_addr_q[11:2] == OFF_LATCH[11:2] && w_strb_q == 4'hF) |=>
      (latch_q == $past(w_data_q[N-1:0])))
    else $error("latch write lost");
  a_pin_follow: assert property (
    $past(ansel_q) == '0 |-> (din_q == $past(sync2_q)))
    else $error("pin level not passed through");
  a_rd_unmapped: assert property (
    (rd_fire && !rd_hit) |=>
      s_rvalid_o && (s_rresp_o == RESP_SLVERR) && (s_rdata_o == 32'h0000_0000))
    else $error("unmapped read answered wrongly");
  a_wr_unmapped: assert property (
    (wr_fire && !wr_hit) |=>
      (latch_q == $past(latch_q)) && (dir_q == $past(dir_q)) && (od_q == $past(od_q)))
    else $error("unmapped write changed state");
  a_dir_hiz: assert property (
    (pad_oe_b_o | ~$past(dir_q & ~cfg_own_i)) == '1)
    else $error("input pin still driven");
endmodule : gpp_port
`default_nettype wire

// ### verif/gpp_pad_model.sv
`timescale 1ns/1ns
`default_nettype none
module gpp_pad_model #(
  parameter int N = 8
) (
  input  wire logic         clk_i,
  input  wire logic [N-1:0] pad_o_i,
  input  wire logic [N-1:0] pad_oe_b_i,
  input  wire logic [N-1:0] pullup_i,
  input  wire logic [N-1:0] ext_en_i,
  input  wire logic [N-1:0] ext_val_i,
  output logic [N-1:0]      level_o
);
  // Pin with no driver, external source or pull-up toggles, so a stale level never passes
  logic [N-1:0] float_q = '0;
  always_ff @(posedge clk_i) begin
    float_q <= ~float_q;
  end
  always_comb begin
    for (int i = 0; i < N; i++) begin
      if (!pad_oe_b_i[i]) level_o[i] = pad_o_i[i];
      else if (ext_en_i[i]) level_o[i] = ext_val_i[i];
      else if (pullup_i[i]) level_o[i] = 1'b1;
      else level_o[i] = float_q[i];
    end
  end
endmodule : gpp_pad_model
`default_nettype wire

// ### verif/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import gpp_pkg::*;
  logic clk_i = 0, rst_b_i = 0;
  logic [11:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [7:0] pad, pad_o, oe_b, pu, thr, slew, din, ain;
  logic [7:0] ext_en = 8'hFF, ext_val = 8'h3C, p_en = '0, p_out = '0;
  logic [7:0] a_en = '0, c_own = '0, c_out = '0, c_oe_b = 8'hFF;
  logic [3:0] wstrb = 4'hF;
  int bad_count = 0, total_checks = 0;
  always #5 clk_i = ~clk_i;
  gpp_port #(.N(8)) uut (.clk_i(clk_i), .rst_b_i(rst_b_i),
    .s_awaddr_i(awaddr), .s_awvalid_i(awvalid), .s_awready_o(awready),
    .s_wdata_i(wdata), .s_wstrb_i(wstrb), .s_wvalid_i(wvalid), .s_wready_o(wready),
    .s_bresp_o(bresp), .s_bvalid_o(bvalid), .s_bready_i(bready),
    .s_araddr_i(araddr), .s_arvalid_i(arvalid), .s_arready_o(arready),
    .s_rdata_o(rdata), .s_rresp_o(rresp), .s_rvalid_o(rvalid), .s_rready_i(rready),
    .pad_i(pad), .pad_o(pad_o), .pad_oe_b_o(oe_b), .pullup_en_o(pu),
    .thresh_sel_o(thr), .slew_lim_o(slew), .din_o(din), .ana_in_en_o(ain),
    .periph_en_i(p_en), .periph_out_i(p_out), .aout_en_i(a_en),
    .cfg_own_i(c_own), .cfg_out_i(c_out), .cfg_oe_b_i(c_oe_b));
  gpp_pad_model #(.N(8)) pins (.clk_i(clk_i), .pad_o_i(pad_o), .pad_oe_b_i(oe_b),
    .pullup_i(pu), .ext_en_i(ext_en), .ext_val_i(ext_val), .level_o(pad));
  task automatic close_out;
    if (bad_count == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : close_out
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic hang(input string nm);
    bad_count++;
    $display("ERROR %s expected answer seen none", nm);
    close_out();
  endtask : hang
  // Sample handshakes at the falling edge, act after the rising one
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ta, tw, tb, done;
    logic [1:0] r;
    done = 0;
    r = '0;
    @(posedge clk_i);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    for (int n = 0; n < 50 && !done; n++) begin
      @(negedge clk_i);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tb = bvalid && bready;
      if (tb) r = bresp;
      @(posedge clk_i);
      if (ta) awvalid <= 0;
      if (tw) wvalid <= 0;
      if (tb) bready <= 0;
      done = tb;
    end
    if (!done) hang("bvalid");
    chk("bresp", {30'h0, r}, {30'h0, er});
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er,
                    input string nm);
    logic ta, tr, done;
    logic [31:0] d;
    logic [1:0] r;
    done = 0;
    d = '0;
    r = '0;
    @(posedge clk_i);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    for (int n = 0; n < 50 && !done; n++) begin
      @(negedge clk_i);
      ta = arvalid && arready;
      tr = rvalid && rready;
      if (tr) begin
        d = rdata;
        r = rresp;
      end
      @(posedge clk_i);
      if (ta) arvalid <= 0;
      if (tr) rready <= 0;
      done = tr;
    end
    if (!done) hang("rvalid");
    chk(nm, d, ed);
    chk("rresp", {30'h0, r}, {30'h0, er});
  endtask : rd
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask : cyc
  function automatic logic [31:0] w8(input logic [7:0] v);
    return {24'h0, v};
  endfunction : w8
  logic [11:0] offs[7] = '{OFF_LATCH, OFF_DIR, OFF_ANSEL, OFF_WPU, OFF_THRESH,
                           OFF_SLEW, OFF_OD};
  logic [31:0] rsts[7] = '{RST_LATCH, RST_DIR, RST_ANSEL, RST_WPU, RST_THRESH,
                           RST_SLEW, RST_OD};
  initial begin
    cyc(16);
    rst_b_i <= 1;
    chk("oe_b rst", w8(oe_b), 32'h0000_00FF);
    for (int i = 0; i < 7; i++) begin
      rd(offs[i], w8(rsts[i][7:0]), RESP_OKAY, "reset value");
    end
    rd(OFF_PIN_LEVEL, 32'h0000_003C, RESP_OKAY, "pin input");
    wr(OFF_PIN_LEVEL, 32'h0000_005A, RESP_OKAY);
    rd(OFF_LATCH, 32'h0000_005A, RESP_OKAY, "latch via pin");
    wr(OFF_LATCH, 32'h0000_0096, RESP_OKAY);
    rd(OFF_LATCH, 32'h0000_0096, RESP_OKAY, "latch");
    wstrb <= 4'h0;
    wr(OFF_LATCH, 32'h0000_00FF, RESP_OKAY);
    wstrb <= 4'hF;
    rd(OFF_LATCH, 32'h0000_0096, RESP_OKAY, "latch no strobe");
    rd(OFF_PIN_LEVEL, 32'h0000_003C, RESP_OKAY, "pin not latch");
    wr(OFF_DIR, 32'h0000_0000, RESP_OKAY);
    cyc(4);
    chk("oe_b out", w8(oe_b), 32'h0000_0000);
    chk("pad out", w8(pad_o), 32'h0000_0096);
    rd(OFF_PIN_LEVEL, 32'h0000_0096, RESP_OKAY, "pin driven");
    wr(OFF_OD, 32'h0000_00FF, RESP_OKAY);
    cyc(4);
    chk("oe_b od", w8(oe_b), 32'h0000_0096);
    chk("pad od low", w8(pad_o & ~oe_b), 32'h0000_0000);
    rd(OFF_PIN_LEVEL, 32'h0000_0014, RESP_OKAY, "pin od");
    wr(OFF_OD, 32'h0000_0000, RESP_OKAY);
    p_en <= 8'h0F;
    p_out <= 8'h05;
    cyc(4);
    chk("pad periph", w8(pad_o), 32'h0000_0095);
    rd(OFF_PIN_LEVEL, 32'h0000_0095, RESP_OKAY, "pin periph");
    p_en <= 8'h00;
    wr(OFF_ANSEL, 32'h0000_000F, RESP_OKAY);
    cyc(4);
    chk("ana in", w8(ain), 32'h0000_000F);
    chk("pad ansel", w8(pad_o), 32'h0000_0096);
    chk("oe_b ansel", w8(oe_b), 32'h0000_0000);
    chk("din ansel", w8(din), 32'h0000_0090);
    rd(OFF_PIN_LEVEL, 32'h0000_0090, RESP_OKAY, "pin ansel");
    a_en <= 8'h03;
    cyc(2);
    chk("oe_b aout", w8(oe_b), 32'h0000_0003);
    c_own <= 8'h02;
    c_out <= 8'h00;
    c_oe_b <= 8'h00;
    cyc(2);
    chk("oe_b cfg", w8(oe_b), 32'h0000_0001);
    chk("pad cfg", w8(pad_o), 32'h0000_0094);
    wr(OFF_WPU, 32'h0000_0011, RESP_OKAY);
    wr(OFF_THRESH, 32'h0000_0022, RESP_OKAY);
    wr(OFF_SLEW, 32'h0000_0044, RESP_OKAY);
    cyc(2);
    chk("pullup", w8(pu), 32'h0000_0011);
    chk("thresh", w8(thr), 32'h0000_0022);
    chk("slew", w8(slew), 32'h0000_0044);
    rd(OFF_SLEW, 32'h0000_0044, RESP_OKAY, "slew rd");
    wr(12'h020, 32'h0000_00FF, RESP_SLVERR);
    rd(12'h020, 32'h0000_0000, RESP_SLVERR, "unmapped");
    rst_b_i <= 0;
    cyc(2);
    rst_b_i <= 1;
    a_en <= 8'h00;
    c_own <= 8'h00;
    cyc(1);
    chk("oe_b rst2", w8(oe_b), 32'h0000_00FF);
    rd(OFF_LATCH, 32'h0000_0000, RESP_OKAY, "latch rst2");
    ext_en <= 8'hF0;
    wr(OFF_WPU, 32'h0000_000F, RESP_OKAY);
    cyc(4);
    rd(OFF_PIN_LEVEL, 32'h0000_003F, RESP_OKAY, "pin pullup");
    close_out();
  end
endmodule : tb_top
`default_nettype wire
